// >>> ptc_periodic_tick.sv
/*
 * Periodic tick counter: source select, binary/decimal prescaler,
 * 8-bit up-counter with modulo match, match flag and interrupt, APB slave.
 * Assumes source clocks far slower than core_clk_in (under a third of it)
 * and a debug indication from logic on the same clock.
 */
`timescale 1ns/1ns

`include "ptc_consts.svh"

// Operation
// - Match sets flag in control bit 7
// - Write one clears flag, zero ignored
// - Reset clears flag, source, enable, divider
// - Codes 00 low power, 01 ext, 1x int
// - New source selection clears prescaler and counter
// - Enable bit gates match flag onto interrupt
// - New divider selection clears prescaler and counter
// - Divide table for source low bit zero
// - Divide table for source low bit one
// - Keeps counting in wait mode
// - Keeps counting in shallow stop modes
// - Deep stop allows only low power source
// - Debug mode freezes prescaler and counter
// - Counting resumes from frozen value
// - Count to limit, wrap, flag on wrap
// - Limit write clears prescaler and counter
// - Count register read only
module ptc_periodic_tick (
    // Clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Source clocks and power state
    input wire ptc_pkg::ptc_src_t src_clk_in,
    input wire logic deep_stop_in,
    input wire logic debug_active_in,
    // Interrupt
    output logic irq_out
);

    // ---------------------------------------------------------------
    // Divide ratio lookup
    // ---------------------------------------------------------------
    function automatic logic [17:0] ptc_divisor(input logic hi,
                                               input logic [3:0] code);
        logic [17:0] d;
        d = `PTC_PRE_ONE;
        unique case ({hi, code})
            5'h01: d = 18'h0_0008;
            5'h02: d = 18'h0_0020;
            5'h03: d = 18'h0_0040;
            5'h04: d = 18'h0_0080;
            5'h05: d = 18'h0_0100;
            5'h06: d = 18'h0_0200;
            5'h07: d = 18'h0_0400;
            5'h08: d = 18'h0_0001;
            5'h09: d = 18'h0_0002;
            5'h0A: d = 18'h0_0004;
            5'h0B: d = 18'h0_000A;
            5'h0C: d = 18'h0_0010;
            5'h0D: d = 18'h0_0064;
            5'h0E: d = 18'h0_01F4;
            5'h0F: d = 18'h0_03E8;
            5'h11: d = 18'h0_0400;
            5'h12: d = 18'h0_0800;
            5'h13: d = 18'h0_1000;
            5'h14: d = 18'h0_2000;
            5'h15: d = 18'h0_4000;
            5'h16: d = 18'h0_8000;
            5'h17: d = 18'h1_0000;
            5'h18: d = 18'h0_03E8;
            5'h19: d = 18'h0_07D0;
            5'h1A: d = 18'h0_1388;
            5'h1B: d = 18'h0_2710;
            5'h1C: d = 18'h0_4E20;
            5'h1D: d = 18'h0_C350;
            5'h1E: d = 18'h1_86A0;
            5'h1F: d = 18'h3_0D40;
            default: d = `PTC_PRE_ONE;
        endcase
        return d;
    endfunction : ptc_divisor

    // ---------------------------------------------------------------
    // State and decode
    // ---------------------------------------------------------------
    ptc_pkg::ptc_state_t s_r;
    ptc_pkg::ptc_state_t s_nxt;

    logic setup;
    logic access;
    logic wr_ctrl;
    logic wr_limit;
    logic wr_mask;
    logic mapped;
    logic src_edge;
    logic src_ok;
    logic tick;
    logic match;
    logic [7:0] wbyte;
    logic [17:0] div_last;

    assign setup = psel_in && !penable_in;
    assign access = psel_in && penable_in && s_r.pready;
    assign wbyte = pwdata_in[7:0];
    assign wr_ctrl = access && pwrite_in && paddr_in == `PTC_OFS_CTRL;
    assign wr_limit = access && pwrite_in && paddr_in == `PTC_OFS_LIMIT;
    assign wr_mask = access && pwrite_in && paddr_in == `PTC_OFS_MASK;
    assign mapped = paddr_in == `PTC_OFS_CTRL
        || paddr_in == `PTC_OFS_COUNT
        || paddr_in == `PTC_OFS_LIMIT
        || paddr_in == `PTC_OFS_MASK;

    // Edge of the chosen source, seen on synced and delayed copies only
    always_comb begin
        unique case (s_r.src_sel)
            `PTC_SRC_LOWPWR: src_edge = s_r.src_sync[`PTC_PIN_LOWPWR]
                && !s_r.src_last[`PTC_PIN_LOWPWR];
            `PTC_SRC_EXT: src_edge = s_r.src_sync[`PTC_PIN_EXT]
                && !s_r.src_last[`PTC_PIN_EXT];
            default: src_edge = s_r.src_sync[`PTC_PIN_INT]
                && !s_r.src_last[`PTC_PIN_INT];
        endcase
    end

    // Wait and shallow stop leave the core clock running, so no gating
    // here; deep stop starves the reference sources.
    assign src_ok = !deep_stop_in
        || s_r.src_sel == `PTC_SRC_LOWPWR;
    assign div_last = ptc_divisor(s_r.src_sel[0], s_r.div_sel)
        - `PTC_PRE_ONE;
    assign tick = src_edge && src_ok && !debug_active_in
        && s_r.div_sel != `PTC_DIV_OFF && s_r.presc == div_last;
    assign match = tick && s_r.cnt == s_r.limit;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // Two stages before any logic looks at a source pin
        s_nxt.src_meta = src_clk_in;
        s_nxt.src_sync = s_r.src_meta;
        s_nxt.src_last = s_r.src_sync;

        // Prescaler and counter; frozen values resume later
        if (src_edge && src_ok && !debug_active_in
            && s_r.div_sel != `PTC_DIV_OFF) begin
            if (tick) begin
                s_nxt.presc = `PTC_PRE_ZERO;
                if (match) begin
                    s_nxt.cnt = `PTC_CNT_ZERO;
                end else begin
                    s_nxt.cnt = s_r.cnt + 8'h01;
                end
            end else begin
                s_nxt.presc = s_r.presc + `PTC_PRE_ONE;
            end
        end

        // APB answer is prepared in the setup cycle
        s_nxt.pready = setup;
        if (setup) begin
            s_nxt.pslverr = !mapped;
            s_nxt.prdata = 32'h0000_0000;
            if (!pwrite_in) begin
                unique case (paddr_in)
                    `PTC_OFS_CTRL: s_nxt.prdata[7:0] = {s_r.flag,
                        s_r.src_sel, s_r.irq_en, s_r.div_sel};
                    `PTC_OFS_COUNT: s_nxt.prdata[7:0] = s_r.cnt;
                    `PTC_OFS_LIMIT: s_nxt.prdata[7:0] = s_r.limit;
                    `PTC_OFS_MASK:
                        s_nxt.prdata[`PTC_FLAG_BIT] = s_r.mask;
                    default: s_nxt.prdata = 32'h0000_0000;
                endcase
            end
        end else begin
            s_nxt.pslverr = 1'b0;
        end

        // Register writes; count register has no write path
        if (wr_ctrl) begin
            s_nxt.src_sel = wbyte[`PTC_SRC_HI:`PTC_SRC_LO];
            s_nxt.irq_en = wbyte[`PTC_IEN_BIT];
            s_nxt.div_sel = wbyte[`PTC_DIV_HI:`PTC_DIV_LO];
            if (wbyte[`PTC_SRC_HI:`PTC_SRC_LO] != s_r.src_sel
                || wbyte[`PTC_DIV_HI:`PTC_DIV_LO] != s_r.div_sel) begin
                s_nxt.presc = `PTC_PRE_ZERO;
                s_nxt.cnt = `PTC_CNT_ZERO;
            end
        end
        if (wr_limit) begin
            s_nxt.limit = wbyte;
            s_nxt.presc = `PTC_PRE_ZERO;
            s_nxt.cnt = `PTC_CNT_ZERO;
        end
        if (wr_mask) begin
            s_nxt.mask = wbyte[`PTC_FLAG_BIT];
        end

        // Flag: a match in the clearing cycle survives the clear
        if (wr_ctrl && wbyte[`PTC_FLAG_BIT]) begin
            s_nxt.flag = 1'b0;
        end
        if (match) begin
            s_nxt.flag = 1'b1;
        end

        // Level request, registered so the pin never glitches
        s_nxt.irq = s_nxt.flag && s_nxt.irq_en && s_nxt.mask;
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
            s_r.mask <= `PTC_MASK_RST;
            s_r.limit <= `PTC_LIMIT_RST;
        end else if (clk_en_in) begin
            s_r <= s_nxt;
        end
    end

    assign prdata_out = s_r.prdata;
    assign pready_out = s_r.pready;
    assign pslverr_out = s_r.pslverr;
    assign irq_out = s_r.irq;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking ck @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    match_sets_flag_a: assert property (
        clk_en_in && match |=> s_r.flag)
        else $error("match did not set flag");

    flag_clear_a: assert property (
        clk_en_in && wr_ctrl && wbyte[`PTC_FLAG_BIT] && !match
        |=> !s_r.flag && !irq_out)
        else $error("write one did not clear flag and request");

    flag_keep_a: assert property (
        clk_en_in && s_r.flag && wr_ctrl && !wbyte[`PTC_FLAG_BIT]
        |=> s_r.flag)
        else $error("write zero changed flag");

    src_change_a: assert property (
        clk_en_in && wr_ctrl
        && wbyte[`PTC_SRC_HI:`PTC_SRC_LO] != s_r.src_sel
        |=> s_r.cnt == `PTC_CNT_ZERO && s_r.presc == `PTC_PRE_ZERO)
        else $error("source change left count running");

    div_change_a: assert property (
        clk_en_in && wr_ctrl
        && wbyte[`PTC_DIV_HI:`PTC_DIV_LO] != s_r.div_sel
        |=> s_r.cnt == `PTC_CNT_ZERO && s_r.presc == `PTC_PRE_ZERO)
        else $error("divider change left count running");

    irq_level_a: assert property (
        clk_en_in |=> irq_out == (s_r.flag && s_r.irq_en && s_r.mask))
        else $error("interrupt level disagrees with flag and enables");

    divider_off_a: assert property (
        s_r.div_sel == `PTC_DIV_OFF && !wr_ctrl && !wr_limit
        |=> $stable(s_r.cnt))
        else $error("counter moved with divider off");

    deep_stop_a: assert property (
        deep_stop_in && s_r.src_sel != `PTC_SRC_LOWPWR
        && !wr_ctrl && !wr_limit
        |=> $stable(s_r.presc) && $stable(s_r.cnt))
        else $error("reference source counted in deep stop");

    debug_freeze_a: assert property (
        debug_active_in && !wr_ctrl && !wr_limit
        |=> $stable(s_r.presc) && $stable(s_r.cnt))
        else $error("count moved in debug mode");

    wrap_zero_a: assert property (
        clk_en_in && match && !wr_ctrl && !wr_limit
        |=> s_r.cnt == `PTC_CNT_ZERO)
        else $error("counter did not wrap on match");

    limit_write_a: assert property (
        clk_en_in && wr_limit
        |=> s_r.cnt == `PTC_CNT_ZERO && s_r.presc == `PTC_PRE_ZERO
            && s_r.limit == $past(wbyte))
        else $error("limit write did not clear counters");

    apb_answer_a: assert property (
        clk_en_in && setup ##1 clk_en_in |-> pready_out)
        else $error("slave did not answer one cycle after setup");

    lowpwr_select_a: assert property (
        clk_en_in && s_r.src_sel == `PTC_SRC_LOWPWR
        && !s_r.src_sync[`PTC_PIN_LOWPWR] && !wr_ctrl && !wr_limit
        |=> $stable(s_r.presc) && $stable(s_r.cnt))
        else $error("low power select counted without its edge");

    ext_select_a: assert property (
        clk_en_in && s_r.src_sel == `PTC_SRC_EXT
        && !s_r.src_sync[`PTC_PIN_EXT] && !wr_ctrl && !wr_limit
        |=> $stable(s_r.presc) && $stable(s_r.cnt))
        else $error("external select counted without its edge");

    int_select_a: assert property (
        clk_en_in && s_r.src_sel >= `PTC_SRC_INT
        && !s_r.src_sync[`PTC_PIN_INT] && !wr_ctrl && !wr_limit
        |=> $stable(s_r.presc) && $stable(s_r.cnt))
        else $error("internal select counted without its edge");

    count_read_a: assert property (
        clk_en_in && setup && !pwrite_in && paddr_in == `PTC_OFS_COUNT
        |=> prdata_out == {24'h00_0000, $past(s_r.cnt)})
        else $error("count read did not return the count");

    count_nowrite_a: assert property (
        clk_en_in && access && pwrite_in && paddr_in == `PTC_OFS_COUNT
        && !tick |=> $stable(s_r.cnt))
        else $error("write to count register changed it");

    count_step_a: assert property (
        clk_en_in && tick && !match && !wr_ctrl && !wr_limit
        |=> s_r.cnt == $past(s_r.cnt) + 8'h01)
        else $error("counter did not step on prescaler output");

    presc_step_a: assert property (
        clk_en_in && src_edge && src_ok && !debug_active_in && !tick
        && s_r.div_sel != `PTC_DIV_OFF && !wr_ctrl && !wr_limit
        |=> s_r.presc == $past(s_r.presc) + `PTC_PRE_ONE)
        else $error("prescaler did not count a source edge");

    presc_bound_a: assert property (
        clk_en_in |-> s_r.presc <= div_last)
        else $error("prescaler ran past its divide ratio");

    limit_zero_a: assert property (
        clk_en_in && tick && s_r.limit == `PTC_CNT_ZERO
        |=> s_r.flag)
        else $error("zero limit did not flag on prescaler output");

    apb_error_a: assert property (
        clk_en_in && setup && !mapped |=> pslverr_out && pready_out)
        else $error("unmapped address gave no error answer");

endmodule : ptc_periodic_tick

// >>> ptc_consts.svh
/*
 * Register offsets, field positions and reset values of the periodic
 * tick counter. Assumes it is included once per compilation unit user.
 */
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define PTC_OFS_CTRL 12'h000
`define PTC_OFS_COUNT 12'h004
`define PTC_OFS_LIMIT 12'h008
`define PTC_OFS_MASK 12'h00C

// ---------------------------------------------------------------
// Field positions in tick_control_status
// ---------------------------------------------------------------
`define PTC_FLAG_BIT 7
`define PTC_SRC_HI 6
`define PTC_SRC_LO 5
`define PTC_IEN_BIT 4
`define PTC_DIV_HI 3
`define PTC_DIV_LO 0

// ---------------------------------------------------------------
// Codes and reset values
// ---------------------------------------------------------------
`define PTC_SRC_LOWPWR 2'h0
`define PTC_SRC_EXT 2'h1
`define PTC_SRC_INT 2'h2
`define PTC_PIN_LOWPWR 0
`define PTC_PIN_EXT 1
`define PTC_PIN_INT 2
`define PTC_DIV_OFF 4'h0
`define PTC_CNT_ZERO 8'h00
`define PTC_LIMIT_RST 8'h00
`define PTC_MASK_RST 1'h1
`define PTC_PRE_ZERO 18'h0_0000
`define PTC_PRE_ONE 18'h0_0001

`endif

// >>> ptc_pkg.sv
/*
 * Types shared by the periodic tick counter.
 * Assumes ptc_consts.svh supplies the numeric constants.
 */
package ptc_pkg;

    // ---------------------------------------------------------------
    // Clock source pins and whole module state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic irc;
        logic ext;
        logic low_pwr;
    } ptc_src_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic [2:0] src_meta;
        logic [2:0] src_sync;
        logic [2:0] src_last;
        logic flag;
        logic [1:0] src_sel;
        logic irq_en;
        logic [3:0] div_sel;
        logic mask;
        logic [17:0] presc;
        logic [7:0] cnt;
        logic [7:0] limit;
    } ptc_state_t;

endpackage : ptc_pkg

// >>> ptc_periodic_tick_tb.sv
/*
 * Self-checking bench for the periodic tick counter over APB.
 * Assumes the design and ptc_consts.svh are compiled alongside.
 */
`timescale 1ns/1ns

`include "ptc_consts.svh"

module ptc_periodic_tick_tb;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic irq_out;
    ptc_pkg::ptc_src_t src = '0;
    logic deep_stop = 1'b0;
    logic debug_act = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] rdata;
    logic rerr;
    int mismatches = 0;
    int num_checks = 0;

    ptc_periodic_tick i_ptc_periodic_tick (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en),
        .psel_in(psel),
        .penable_in(penable),
        .pwrite_in(pwrite),
        .paddr_in(paddr),
        .pwdata_in(pwdata),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .src_clk_in(src),
        .deep_stop_in(deep_stop),
        .debug_active_in(debug_act),
        .irq_out(irq_out)
    );

    initial begin
        forever #10 core_clk_in = ~core_clk_in;
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_in);
        end while (pready_out !== 1'b1);
        rdata = prdata_out;
        rerr = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_reg(rdata, {24'h00_0000, exp});
    endtask : rd

    // Source edges kept well under a third of the core rate
    task automatic edges(input int idx, input int n);
        repeat (n) begin
            @(posedge core_clk_in);
            src[idx] <= 1'b1;
            repeat (4) @(posedge core_clk_in);
            src[idx] <= 1'b0;
            repeat (4) @(posedge core_clk_in);
        end
        repeat (4) @(posedge core_clk_in);
    endtask : edges

    task automatic irq_is(input logic exp);
        repeat (3) @(negedge core_clk_in);
        chk_bit(irq_out, exp);
    endtask : irq_is

    // ---------------------------------------------------------------
    // Watchdog and tests
    // ---------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge core_clk_in);
        mismatches++;
        final_report();
    end

    initial begin
        repeat (4) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        irq_is(1'b0);
        rd(`PTC_OFS_CTRL, 8'h00);
        rd(`PTC_OFS_LIMIT, 8'h00);
        rd(`PTC_OFS_COUNT, 8'h00);
        rd(`PTC_OFS_MASK, 8'h80);
        rd(12'h010, 8'h00);
        chk_bit(rerr, 1'b1);
        wr(`PTC_OFS_COUNT, 8'h55);
        rd(`PTC_OFS_COUNT, 8'h00);
        wr(`PTC_OFS_LIMIT, 8'h03);
        rd(`PTC_OFS_LIMIT, 8'h03);
        // Low power source, divide by one
        wr(`PTC_OFS_CTRL, 8'h08);
        edges(0, 3);
        rd(`PTC_OFS_COUNT, 8'h03);
        rd(`PTC_OFS_CTRL, 8'h08);
        edges(0, 1);
        rd(`PTC_OFS_COUNT, 8'h00);
        rd(`PTC_OFS_CTRL, 8'h88);
        irq_is(1'b0);
        wr(`PTC_OFS_CTRL, 8'h18);
        irq_is(1'b1);
        rd(`PTC_OFS_CTRL, 8'h98);
        wr(`PTC_OFS_MASK, 8'h00);
        irq_is(1'b0);
        wr(`PTC_OFS_MASK, 8'h80);
        irq_is(1'b1);
        wr(`PTC_OFS_CTRL, 8'h98);
        irq_is(1'b0);
        rd(`PTC_OFS_CTRL, 8'h18);
        // Debug freeze and resume
        edges(0, 2);
        debug_act <= 1'b1;
        edges(0, 3);
        rd(`PTC_OFS_COUNT, 8'h02);
        debug_act <= 1'b0;
        edges(0, 1);
        rd(`PTC_OFS_COUNT, 8'h03);
        wr(`PTC_OFS_LIMIT, 8'h10);
        rd(`PTC_OFS_COUNT, 8'h00);
        // Internal source only follows its own pin
        edges(0, 2);
        wr(`PTC_OFS_CTRL, 8'h48);
        rd(`PTC_OFS_COUNT, 8'h00);
        edges(0, 2);
        edges(1, 2);
        edges(2, 2);
        rd(`PTC_OFS_COUNT, 8'h02);
        deep_stop <= 1'b1;
        edges(2, 2);
        rd(`PTC_OFS_COUNT, 8'h02);
        deep_stop <= 1'b0;
        wr(`PTC_OFS_CTRL, 8'h49);
        rd(`PTC_OFS_COUNT, 8'h00);
        edges(2, 4);
        rd(`PTC_OFS_COUNT, 8'h02);
        wr(`PTC_OFS_CTRL, 8'h41);
        edges(2, 8);
        rd(`PTC_OFS_COUNT, 8'h01);
        // External source, decimal code 8 divides by 1000
        wr(`PTC_OFS_CTRL, 8'h28);
        edges(1, 999);
        rd(`PTC_OFS_COUNT, 8'h00);
        edges(1, 1);
        rd(`PTC_OFS_COUNT, 8'h01);
        // Deep stop still counts the low power source
        wr(`PTC_OFS_CTRL, 8'h08);
        deep_stop <= 1'b1;
        edges(0, 1);
        rd(`PTC_OFS_COUNT, 8'h01);
        deep_stop <= 1'b0;
        // Software stops the counter when it is not needed
        wr(`PTC_OFS_LIMIT, 8'h10);
        edges(0, 1);
        rd(`PTC_OFS_COUNT, 8'h01);
        wr(`PTC_OFS_CTRL, 8'h80);
        edges(0, 2);
        rd(`PTC_OFS_COUNT, 8'h00);
        // Clock enable low freezes every flop
        wr(`PTC_OFS_CTRL, 8'h08);
        clk_en <= 1'b0;
        edges(0, 2);
        clk_en <= 1'b1;
        rd(`PTC_OFS_COUNT, 8'h00);
        edges(0, 1);
        rd(`PTC_OFS_COUNT, 8'h01);
        // Zero limit flags every prescaler output; reset clears it all
        wr(`PTC_OFS_LIMIT, 8'h00);
        wr(`PTC_OFS_CTRL, 8'h58);
        edges(2, 1);
        rd(`PTC_OFS_CTRL, 8'hD8);
        irq_is(1'b1);
        @(posedge core_clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        irq_is(1'b0);
        rd(`PTC_OFS_CTRL, 8'h00);
        final_report();
    end
endmodule : ptc_periodic_tick_tb
